//--- design/beat_fifo.sv
/*
  synchronous fifo for bus beats, width and depth as parameters.
  assumes one clock; depth a power of two.
*/
module beat_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = icache_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("beat_fifo depth must be a power of two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic full;
  logic empty;

  assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty = wr_r == rd_r;
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (in_valid && !full) wr_r <= wr_r + 1'b1;
      if (out_ready && !empty) rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[wr_r[AW-1:0]] <= in_data;
  end
endmodule : beat_fifo

//--- design/icache_pkg.sv
/*
  shared constants and types for the instruction cache: special register
  numbers, control/status field positions, command codes, address fields
  and the carriers for bus beats and fetch answers.
  assumes the processor numbers bits big-endian, so bit 0 is the msb.
*/
package icache_pkg;
  localparam int SETS = 128;
  localparam int WORDS = 4;
  localparam int TAG_W = 21;
  localparam int IDX_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam logic [9:0] SPR_CTRL = 10'h230;
  localparam logic [9:0] SPR_ADDR = 10'h231;
  localparam logic [9:0] SPR_DATA = 10'h232;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int ENABLED_BIT = 31;
  localparam int CMD_LSB = 25;
  localparam int ERR1_BIT = 21;
  localparam int ERR2_BIT = 20;
  localparam int ERR3_BIT = 19;
  localparam int DBG_TAG_BIT = 12;
  localparam int DBG_WAY_BIT = 11;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ENABLE, CMD_DISABLE, CMD_LOAD_LOCK,
    CMD_UNLOCK_LINE, CMD_UNLOCK_ALL, CMD_INVALIDATE_ALL, CMD_RESERVED
  } cmd_type;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [IDX_W-1:0] idx;
    logic [1:0] word;
    logic [1:0] byte_sel;
  } addr_type;

  typedef struct packed {
    logic [31:0] data;
    logic err;
    logic nocache;
  } beat_type;

  typedef struct packed {
    logic [31:0] data;
    logic mcheck;
  } rsp_type;
endpackage : icache_pkg

//--- design/instruction_cache.sv
/*
  two-way set associative instruction cache with line locking, stream
  hits, pipelined misses and special-register control.
  assumes the instruction bus answers each started burst with four beats
  in order, critical word first, and ignores a start that is aborted.
*/
module instruction_cache #(
  parameter int FIFO_DEPTH = icache_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  output logic fetch_ready,
  input wire logic region_inhibit,
  output logic rsp_valid,
  output icache_pkg::rsp_type rsp,
  input wire logic rsp_ready,
  input wire logic icbi_valid,
  input wire logic [31:0] icbi_addr,
  input wire logic spr_valid,
  input wire logic spr_write,
  input wire logic spr_user,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  output logic spr_ack,
  output logic spr_prog_exc,
  output logic [31:0] spr_rdata,
  output logic cmd_busy,
  output logic bus_start,
  output logic bus_abort,
  output logic bus_burst,
  output logic [31:0] bus_addr,
  input wire logic beat_valid,
  input wire icache_pkg::beat_type beat,
  output logic beat_ready
);
  typedef enum {ST_IDLE, ST_FILL, ST_SINGLE} state_type;

  // arrays: 128 sets x 2 ways x 4 words
  logic [icache_pkg::TAG_W-1:0] tag_mem [2][icache_pkg::SETS];
  logic [31:0] data_mem [2][icache_pkg::SETS*icache_pkg::WORDS];
  logic [icache_pkg::SETS-1:0] valid_r [2];
  logic [icache_pkg::SETS-1:0] lock_r [2];
  logic [icache_pkg::SETS-1:0] lru_r;

  state_type state_r, state_nxt;
  logic [31:0] fill_addr_r, pend_addr_r, adr_r;
  logic [31:0] bb_r [4];
  logic [3:0] have_r;
  logic [1:0] cnt_r;
  logic fill_lock_r, bad_r, nc_r, pend_r, en_r, cmd_pend_r;
  logic [2:0] err_r;
  logic rsp_valid_r, spr_ack_r, spr_exc_r;
  icache_pkg::rsp_type rsp_r, rsp_nxt;
  logic [31:0] spr_rdata_r, ctrl_rd, dbg_rd;

  // line lookup by tag and index
  function automatic logic [1:0] lookup(input logic [31:0] a);
    icache_pkg::addr_type f;
    f = icache_pkg::addr_type'(a);
    lookup[0] = valid_r[0][f.idx] && tag_mem[0][f.idx] == f.tag;
    lookup[1] = valid_r[1][f.idx] && tag_mem[1][f.idx] == f.tag;
  endfunction : lookup

  // victim choice: {usable, way}
  function automatic logic [1:0] pick(input logic [6:0] s);
    if (!valid_r[0][s]) pick = 2'h2;
    else if (!valid_r[1][s]) pick = 2'h3;
    else if (lock_r[0][s] && lock_r[1][s]) pick = 2'h0;
    else if (lock_r[0][s]) pick = 2'h3;
    else if (lock_r[1][s]) pick = 2'h2;
    else pick = {1'b1, lru_r[s]};
  endfunction : pick

  // beat fifo in the refill path
  icache_pkg::beat_type q;
  logic q_valid, q_ready, pop;

  beat_fifo #(
    .WIDTH($bits(icache_pkg::beat_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(beat_valid),
    .in_ready(beat_ready),
    .in_data(beat),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q)
  );

  icache_pkg::addr_type f, fa, aa;
  logic [1:0] fh, fv, ah, av, ih, vic, wpos;
  logic in_fill, crit, same, s_buf, s_bus, a_hit, cacheable;
  logic tail_ok, idle_ok, slot, take, serve, miss, rsp_busy;
  logic go_fill, go_single, lock_now, lock_go, lock_nospace, lock_hit;
  logic last, line_bad, wr_line, st_now;
  logic [31:0] st_addr;
  logic spr_sel, spr_ok, ctrl_wr;
  icache_pkg::cmd_type cmd;
  logic [2:0] err_set, err_keep;

  assign f = icache_pkg::addr_type'(fetch_addr);
  assign fa = icache_pkg::addr_type'(fill_addr_r);
  assign aa = icache_pkg::addr_type'(adr_r);
  assign fh = lookup(fetch_addr);
  assign fv = pick(f.idx);
  assign ah = lookup(adr_r);
  assign av = pick(aa.idx);
  assign ih = lookup(icbi_addr);
  assign vic = pick(fa.idx);
  assign wpos = 2'(fa.word + cnt_r);

  // fetch acceptance
  assign in_fill = state_r == ST_FILL;
  assign crit = |have_r;
  assign same = {f.tag, f.idx} == {fa.tag, fa.idx};
  assign s_buf = in_fill && !fill_lock_r && same && have_r[f.word];
  assign s_bus = in_fill && !fill_lock_r && same && pop &&
                 cnt_r != 2'h0 && wpos == f.word;
  assign a_hit = en_r && |fh;
  assign cacheable = en_r && !region_inhibit;
  assign tail_ok = in_fill && crit && !fill_lock_r && !pend_r &&
                   cacheable && fv[1] && !same;
  assign idle_ok = state_r == ST_IDLE && !cmd_pend_r;
  assign rsp_busy = rsp_valid_r && !rsp_ready;
  assign slot = !rsp_busy && !(pop && (state_r == ST_SINGLE ||
                (cnt_r == 2'h0 && !fill_lock_r)));
  assign fetch_ready = slot && (a_hit || s_buf || s_bus || idle_ok || tail_ok);
  assign take = fetch_valid && fetch_ready;
  assign serve = take && (a_hit || s_buf || s_bus);
  assign miss = take && !(a_hit || s_buf || s_bus);
  assign go_fill = miss && cacheable && fv[1];
  assign go_single = miss && !go_fill;

  // load-and-lock runs from idle
  assign lock_now = cmd_pend_r && state_r == ST_IDLE;
  assign lock_hit = lock_now && |ah;
  assign lock_go = lock_now && !(|ah) && av[1];
  assign lock_nospace = lock_now && !(|ah) && !av[1];

  // bus request side
  assign bus_start = lock_go || (take && !s_buf && !s_bus);
  assign bus_abort = take && a_hit && !lock_go;
  assign bus_burst = lock_go || go_fill;
  assign bus_addr = lock_go ? adr_r : fetch_addr;

  // refill draining
  assign q_ready = state_r != ST_IDLE && !rsp_busy;
  assign pop = q_valid && q_ready;
  assign last = pop && in_fill && cnt_r == 2'h3;
  assign line_bad = bad_r || q.err || nc_r;
  assign wr_line = last && !line_bad && vic[1];
  assign st_now = (state_r == ST_IDLE && (lock_go || go_fill)) ||
                  (last && (pend_r || go_fill));
  assign st_addr = lock_go ? adr_r : (pend_r ? pend_addr_r : fetch_addr);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (st_now) state_nxt = ST_FILL;
        else if (go_single) state_nxt = ST_SINGLE;
      end
      ST_SINGLE: begin
        if (pop) state_nxt = ST_IDLE;
      end
      ST_FILL: begin
        if (last && !st_now) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // answer to the instruction unit
  always_comb begin
    rsp_nxt = rsp_r;
    if (take && a_hit) rsp_nxt = {data_mem[fh[1]][{f.idx, f.word}], 1'b0};
    else if (take && s_buf) rsp_nxt = {bb_r[f.word], 1'b0};
    else if (pop) rsp_nxt = {q.data, q.err};
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      rsp_valid_r <= serve || (pop && (state_r == ST_SINGLE ||
                     (in_fill && cnt_r == 2'h0 && !fill_lock_r))) || rsp_busy;
      if (!rsp_busy) rsp_r <= rsp_nxt;
    end
  end

  // refill context
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      fill_addr_r <= '0;
      fill_lock_r <= 1'b0;
      cnt_r <= 2'h0;
      have_r <= 4'h0;
      bad_r <= 1'b0;
      nc_r <= 1'b0;
      pend_r <= 1'b0;
      pend_addr_r <= '0;
      for (int k = 0; k < 4; k++) bb_r[k] <= '0;
    end else begin
      state_r <= state_nxt;
      if (st_now) begin
        fill_addr_r <= st_addr;
        fill_lock_r <= lock_go;
        cnt_r <= 2'h0;
        have_r <= 4'h0;
        bad_r <= 1'b0;
        nc_r <= 1'b0;
      end else if (pop && in_fill) begin
        bb_r[wpos] <= q.data;
        have_r[wpos] <= 1'b1;
        cnt_r <= cnt_r + 2'h1;
        bad_r <= bad_r || q.err;
        if (cnt_r == 2'h0) nc_r <= q.nocache;
      end
      if (last) pend_r <= 1'b0;
      else if (go_fill && in_fill) begin
        pend_r <= 1'b1;
        pend_addr_r <= fetch_addr;
      end
    end
  end

  // tag and data array writes
  always_ff @(posedge clk) begin
    if (wr_line) begin
      tag_mem[vic[0]][fa.idx] <= fa.tag;
      for (int k = 0; k < 4; k++)
        data_mem[vic[0]][{fa.idx, 2'(k)}] <=
          (2'(k) == wpos) ? q.data : bb_r[k];
    end
  end

  // valid, lock and lru state
  assign spr_sel = spr_num == icache_pkg::SPR_CTRL ||
                   spr_num == icache_pkg::SPR_ADDR ||
                   spr_num == icache_pkg::SPR_DATA;
  assign spr_ok = spr_valid && spr_sel && !spr_user;
  assign ctrl_wr = spr_ok && spr_write && spr_num == icache_pkg::SPR_CTRL;
  assign cmd = icache_pkg::cmd_type'(spr_wdata[icache_pkg::CMD_LSB +: 3]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_r[0] <= '0;
      valid_r[1] <= '0;
      lock_r[0] <= '0;
      lock_r[1] <= '0;
      lru_r <= '0;
    end else begin
      if (take && a_hit) lru_r[f.idx] <= ~fh[1];
      for (int w = 0; w < 2; w++) begin
        if (icbi_valid && ih[w] && !lock_r[w][icbi_addr[10:4]])
          valid_r[w][icbi_addr[10:4]] <= 1'b0;
        if (lock_hit && ah[w]) lock_r[w][aa.idx] <= 1'b1;
        if (ctrl_wr && cmd == icache_pkg::CMD_UNLOCK_LINE && ah[w])
          lock_r[w][aa.idx] <= 1'b0;
      end
      if (wr_line) begin
        valid_r[vic[0]][fa.idx] <= 1'b1;
        lru_r[fa.idx] <= ~vic[0];
        if (fill_lock_r) lock_r[vic[0]][fa.idx] <= 1'b1;
      end
      if (ctrl_wr && cmd == icache_pkg::CMD_UNLOCK_ALL) begin
        lock_r[0] <= '0;
        lock_r[1] <= '0;
      end
      if (ctrl_wr && cmd == icache_pkg::CMD_INVALIDATE_ALL) begin
        valid_r[0] <= valid_r[0] & lock_r[0];
        valid_r[1] <= valid_r[1] & lock_r[1];
        lru_r <= lock_r[0] & ~lock_r[1];
      end
    end
  end

  // control, enable and sticky errors
  assign err_set[2] = (last && fill_lock_r && (bad_r || q.err));
  assign err_set[1] = lock_nospace || (last && fill_lock_r && !vic[1]);
  assign err_set[0] = last && fill_lock_r && !(bad_r || q.err) && nc_r;
  assign err_keep = ctrl_wr ? {spr_wdata[icache_pkg::ERR1_BIT],
                    spr_wdata[icache_pkg::ERR2_BIT],
                    spr_wdata[icache_pkg::ERR3_BIT]} : 3'h7;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
      err_r <= 3'h0;
      cmd_pend_r <= 1'b0;
      adr_r <= '0;
    end else begin
      err_r <= err_set | (err_r & err_keep);
      if (ctrl_wr && cmd == icache_pkg::CMD_ENABLE) en_r <= 1'b1;
      if (ctrl_wr && cmd == icache_pkg::CMD_DISABLE) en_r <= 1'b0;
      if (ctrl_wr && cmd == icache_pkg::CMD_LOAD_LOCK) cmd_pend_r <= 1'b1;
      else if (lock_now) cmd_pend_r <= 1'b0;
      if (spr_ok && spr_write && spr_num == icache_pkg::SPR_ADDR)
        adr_r <= spr_wdata;
    end
  end

  // register read view
  always_comb begin
    ctrl_rd = icache_pkg::CTRL_RESET;
    ctrl_rd[icache_pkg::ENABLED_BIT] = en_r;
    ctrl_rd[icache_pkg::ERR1_BIT] = err_r[2];
    ctrl_rd[icache_pkg::ERR2_BIT] = err_r[1];
    ctrl_rd[icache_pkg::ERR3_BIT] = err_r[0];
  end

  logic dbg_way;
  assign dbg_way = adr_r[icache_pkg::DBG_WAY_BIT];
  assign dbg_rd = adr_r[icache_pkg::DBG_TAG_BIT] ?
                  {tag_mem[dbg_way][aa.idx], 7'h00, valid_r[dbg_way][aa.idx],
                   lock_r[dbg_way][aa.idx], lru_r[aa.idx], 1'b0} :
                  data_mem[dbg_way][{aa.idx, aa.word}];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spr_ack_r <= 1'b0;
      spr_exc_r <= 1'b0;
      spr_rdata_r <= '0;
    end else begin
      spr_ack_r <= spr_valid && spr_sel;
      spr_exc_r <= spr_valid && spr_sel && spr_user;
      if (spr_ok && !spr_write) begin
        case (spr_num)
          icache_pkg::SPR_CTRL: spr_rdata_r <= ctrl_rd;
          icache_pkg::SPR_ADDR: spr_rdata_r <= adr_r;
          icache_pkg::SPR_DATA: spr_rdata_r <= dbg_rd;
          default: spr_rdata_r <= '0;
        endcase
      end else begin
        spr_rdata_r <= '0;
      end
    end
  end

  assign spr_ack = spr_ack_r;
  assign spr_prog_exc = spr_exc_r;
  assign spr_rdata = spr_rdata_r;
  assign cmd_busy = cmd_pend_r || (in_fill && fill_lock_r);
endmodule : instruction_cache

//--- test/ibus_model.sv
/*
  instruction bus model: answers each unaborted start with beats.
  assumes starts arrive in order; injects errors when told to.
*/
module ibus_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_start,
  input wire logic bus_abort,
  input wire logic bus_burst,
  input wire logic [31:0] bus_addr,
  input wire logic beat_ready,
  input wire logic slow,
  input wire logic err_inj,
  input wire logic nc_inj,
  output logic beat_valid,
  output icache_pkg::beat_type beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  logic [31:0] a_r;
  logic [2:0] left_r;
  logic gap_r;
  logic [31:0] w;
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'h3c5a96e1;
  endfunction : mem_word
  assign w = mem_word(a_r);
  assign beat_valid = left_r != 3'h0 && !(slow && gap_r);
  // released bus shows inverted data
  assign beat.data = beat_valid ? w : ~w;
  assign beat.err = err_inj;
  assign beat.nocache = nc_inj;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_r <= 3'h0;
      gap_r <= 1'h0;
      q = {};
    end else begin
      if (bus_start && !bus_abort) q.push_back({bus_addr[31:1], bus_burst});
      if (!(beat_valid && !beat_ready)) gap_r <= ~gap_r;
      if (beat_valid && beat_ready) begin
        left_r <= left_r - 3'h1;
        a_r[3:2] <= a_r[3:2] + 2'h1; // wrap in line
      end else if (left_r == 3'h0 && q.size() != 0) begin
        a_r <= {q[0][31:1], 1'h0};
        left_r <= q[0][0] ? 3'h4 : 3'h1;
        void'(q.pop_front());
      end
    end
  end
endmodule : ibus_model

//--- test/icache_chk_asserts.sv
/*
  checker for the instruction cache top ports.
  assumes binding to instruction_cache; single clock, async low reset.
*/
module icache_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_ready,
  input wire logic region_inhibit,
  input wire logic rsp_valid,
  input wire icache_pkg::rsp_type rsp,
  input wire logic rsp_ready,
  input wire logic spr_valid,
  input wire logic spr_write,
  input wire logic spr_user,
  input wire logic [9:0] spr_num,
  input wire logic spr_ack,
  input wire logic spr_prog_exc,
  input wire logic [31:0] spr_rdata,
  input wire logic cmd_busy,
  input wire logic bus_start,
  input wire logic bus_abort,
  input wire logic bus_burst,
  input wire logic [31:0] bus_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rng;
  wire logic take;
  assign rng = spr_num >= icache_pkg::SPR_CTRL &&
    spr_num <= icache_pkg::SPR_DATA;
  assign take = fetch_valid && fetch_ready && bus_start;
  a_ack_next: assert property (spr_valid && rng |=> spr_ack)
    else $error("no ack after register access");
  a_ack_quiet: assert property (!(spr_valid && rng) |=> !spr_ack)
    else $error("ack without register access");
  a_exc_user: assert property (spr_valid && rng && spr_user |=>
    spr_prog_exc) else $error("user access without exception");
  a_exc_ack: assert property (spr_prog_exc |-> spr_ack)
    else $error("exception without ack");
  a_ctrl_rsvd: assert property (spr_valid && rng && !spr_write &&
    !spr_user && spr_num == icache_pkg::SPR_CTRL |=>
    (spr_rdata & 32'h7fc7ffff) == 32'h0)
    else $error("reserved status bits not zero");
  a_rdata_idle: assert property (!spr_ack |-> spr_rdata == 32'h0)
    else $error("read data outside ack");
  a_abort_start: assert property (bus_abort |-> bus_start)
    else $error("abort without start");
  a_hit_rsp: assert property (take && bus_abort |=> rsp_valid)
    else $error("hit not answered next cycle");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp)) else $error("answer dropped or changed");
  a_start_addr: assert property (take && !cmd_busy |->
    bus_addr == fetch_addr) else $error("bus address not fetch address");
  a_inhibit_single: assert property (take && region_inhibit && !cmd_busy |->
    !bus_burst) else $error("burst on inhibited region");
  c_hit: cover property (take && bus_abort);
  c_miss: cover property (take && !bus_abort && bus_burst);
  c_user: cover property (spr_prog_exc);
endmodule : icache_chk

//--- test/instruction_cache_tb_top.sv
/*
  self-checking bench for the instruction cache.
  assumes the bus model answers starts; rsp_ready stalls at random.
*/
module instruction_cache_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] C0 = icache_pkg::SPR_CTRL;
  localparam logic [9:0] C1 = icache_pkg::SPR_ADDR;
  localparam logic [31:0] ENB = 32'h80000000;
  logic clk = 0, resetn = 0, fetch_valid = 0, region_inhibit = 0;
  logic rsp_ready = 1, icbi_valid = 0, spr_valid = 0, spr_write = 0;
  logic spr_user = 0, slow = 0, err_inj = 0, nc_inj = 0;
  logic [31:0] fetch_addr = 0, icbi_addr = 0, spr_wdata = 0;
  logic [9:0] spr_num = 0;
  logic fetch_ready, rsp_valid, spr_ack, spr_prog_exc, cmd_busy;
  logic bus_start, bus_abort, bus_burst, beat_valid, beat_ready, burst_l;
  logic [31:0] spr_rdata, bus_addr, rd, d, a, la[5];
  icache_pkg::rsp_type rsp;
  icache_pkg::beat_type beat;
  int errors = 0, n_tests = 0, n_st = 0, n, i, k, fl[5];
  always #5 clk = ~clk;
  instruction_cache dut (.clk(clk), .resetn(resetn),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .region_inhibit(region_inhibit),
    .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready),
    .icbi_valid(icbi_valid), .icbi_addr(icbi_addr),
    .spr_valid(spr_valid), .spr_write(spr_write), .spr_user(spr_user),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .spr_ack(spr_ack),
    .spr_prog_exc(spr_prog_exc), .spr_rdata(spr_rdata),
    .cmd_busy(cmd_busy), .bus_start(bus_start), .bus_abort(bus_abort),
    .bus_burst(bus_burst), .bus_addr(bus_addr), .beat_valid(beat_valid),
    .beat(beat), .beat_ready(beat_ready));
  ibus_model bus (.clk(clk), .resetn(resetn), .bus_start(bus_start),
    .bus_abort(bus_abort), .bus_burst(bus_burst), .bus_addr(bus_addr),
    .beat_ready(beat_ready), .slow(slow), .err_inj(err_inj),
    .nc_inj(nc_inj), .beat_valid(beat_valid), .beat(beat));
  always @(posedge clk) begin
    if (bus_start && !bus_abort) begin
      n_st++;
      burst_l = bus_burst;
    end
    rsp_ready <= ($urandom % 4) != 0;
  end
  function automatic logic [31:0] exp_word(input logic [31:0] x);
    return {x[31:2], 2'h0} ^ 32'h3c5a96e1;
  endfunction : exp_word
  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bound(input int c);
    if (c >= 300) begin
      errors++;
      tally_and_finish();
    end
  endtask : bound
  task automatic spr(input logic w, input logic [9:0] s,
    input logic [31:0] v, input logic u);
    @(posedge clk);
    spr_valid <= 1'h1;
    spr_write <= w;
    spr_num <= s;
    spr_wdata <= v;
    spr_user <= u;
    @(posedge clk);
    spr_valid <= 1'h0;
    #1;
    rd = spr_rdata;
  endtask : spr
  task automatic ce(input int c);
    spr(1'h1, C0, 32'(c) << icache_pkg::CMD_LSB, 1'h0);
    i = 0;
    do begin @(posedge clk); #1; i++; end while (cmd_busy !== 1'h0 && i < 300);
    bound(i);
  endtask : ce
  task automatic fetch(input logic [31:0] x, input logic inh);
    @(posedge clk);
    fetch_valid <= 1'h1;
    fetch_addr <= x;
    region_inhibit <= inh;
    i = 0;
    do begin if (i) @(posedge clk); #1; i++; end
    while (fetch_ready !== 1'h1 && i < 300);
    bound(i);
    @(posedge clk);
    fetch_valid <= 1'h0;
    i = 0;
    do begin if (i) @(posedge clk); #1; i++; end
    while ((rsp_valid & rsp_ready) !== 1'h1 && i < 300);
    bound(i);
    chk(rsp.data, exp_word(x));
  endtask : fetch
  initial begin
    void'($urandom(93));
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    spr(1'h0, C0, 0, 1'h0);
    chk(rd, 32'h0);
    spr(1'h0, 10'h233, 0, 1'h0);
    chk(spr_ack, 1'h0);
    spr(1'h1, C1, 32'ha5a5f0f0, 1'h0);
    spr(1'h0, C1, 0, 1'h0);
    chk(rd, 32'ha5a5f0f0);
    ce(6);
    ce(5);
    ce(1);
    spr(1'h1, C0, 32'(2) << icache_pkg::CMD_LSB, 1'h1);
    chk(spr_prog_exc, 1'h1);
    for (k = 0; k < 2; k++) begin
      spr(1'h1, C0, 32'(k * 7) << icache_pkg::CMD_LSB, 1'h0);
      spr(1'h0, C0, 0, 1'h0);
      chk(rd, ENB);
    end
    n = n_st;
    for (k = 0; k < 4; k++) fetch(32'h2020 | 32'(((k + 2) % 4) * 4), 1'h0);
    chk(n_st, n + 1);
    chk(burst_l, 1'h1);
    fetch(32'h0100, 1'h0);
    fetch(32'h0900, 1'h0);
    fetch(32'h0100, 1'h0);
    fetch(32'h1100, 1'h0);
    n = n_st;
    fetch(32'h0104, 1'h0);
    chk(n_st, n);
    fetch(32'h0904, 1'h0);
    chk(n_st, n + 1);
    for (k = 0; k < 40; k++) begin
      slow = k[0];
      fetch($urandom & 32'h0000187c, 1'h0);
    end
    la = '{32'h340, 32'hb40, 32'h1340, 32'h560, 32'h780};
    fl = '{0, 0, 20, 21, 19};
    for (k = 0; k < 5; k++) begin
      err_inj = k == 3;
      nc_inj = k == 4;
      spr(1'h1, C1, la[k], 1'h0);
      ce(3);
      err_inj = 0;
      nc_inj = 0;
      spr(1'h0, C0, 0, 1'h0);
      chk(rd, ENB | (fl[k] ? 32'h1 << fl[k] : 0));
      spr(1'h1, C0, 32'h0, 1'h0);
    end
    d = 0;
    for (k = 0; k < 2; k++) begin
      spr(1'h1, C1, 32'h1340 | 32'(k) << 11, 1'h0);
      spr(1'h0, icache_pkg::SPR_DATA, 0, 1'h0);
      d |= 32'((rd & 32'hfffffffd) === 32'hc);
    end
    chk(d, 1);
    ce(6);
    n = n_st;
    fetch(32'h0344, 1'h0);
    chk(n_st, n);
    spr(1'h1, C1, 32'h340, 1'h0);
    ce(4);
    ce(6);
    fetch(32'h0348, 1'h0);
    chk(n_st, n + 1);
    a = 32'h0348;
    repeat (20) @(posedge clk);
    icbi_valid <= 1'h1;
    icbi_addr <= a;
    @(posedge clk);
    icbi_valid <= 1'h0;
    fetch(a, 1'h0);
    chk(n_st, n + 2);
    for (k = 0; k < 2; k++) begin
      if (k == 0) ce(2);
      n = n_st;
      fetch(32'h4400, k[0]);
      fetch(32'h4400, k[0]);
      chk(n_st, n + 2);
      chk(burst_l, 1'h0);
      ce(1);
    end
    tally_and_finish();
  end
endmodule : instruction_cache_tb_top
bind instruction_cache icache_chk chk_i (.clk(clk), .resetn(resetn),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .fetch_ready(fetch_ready), .region_inhibit(region_inhibit),
  .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready),
  .spr_valid(spr_valid), .spr_write(spr_write), .spr_user(spr_user),
  .spr_num(spr_num), .spr_ack(spr_ack), .spr_prog_exc(spr_prog_exc),
  .spr_rdata(spr_rdata), .cmd_busy(cmd_busy), .bus_start(bus_start),
  .bus_abort(bus_abort), .bus_burst(bus_burst), .bus_addr(bus_addr));
